// ---- steer_pkg.sv ----
// Shared constants of the steering angle reporter and its controller.
// Assumes one 100 MHz clock and frame-level transfer over the link.
`default_nettype none

package steer_pkg;
  // Clock and time base
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int TIMEOUT_MS = 1000;
  // Report periods in ms
  localparam int PER_SHORT_MS = 5;
  localparam int PER_MID_MS = 10;
  localparam int PER_LONG_MS = 20;
  // Frame identifiers
  localparam logic [10:0] RPT_ID = 11'h301;
  localparam logic [10:0] SET_ID = 11'h0c0;
  // Setup codes for bit rate and period
  localparam logic [7:0] CODE_LO = 8'h02;
  localparam logic [7:0] CODE_MID = 8'h03;
  localparam logic [7:0] CODE_HI = 8'h04;
  // Sequence keys
  localparam logic [7:0] OPEN_A = 8'haa;
  localparam logic [7:0] OPEN_B = 8'h55;
  localparam logic [7:0] CLOSE_A = 8'h0f;
  localparam logic [7:0] CLOSE_B = 8'hf0;
  localparam logic [7:0] ZERO_KEY = 8'haa;
  // CRC-16, polynomial x^16+x^15+x^2+1
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // Values after reset
  localparam logic [11:0] ZERO_RESET = 12'h000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // Controller register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_REPORT = 8'h0c;
  localparam logic [7:0] REG_CHANGE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // CRC over bytes 0..5, byte 0 first, msb first
  function automatic logic [15:0] crc16(input logic [47:0] d);
    logic [15:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 0; i < 6; i++)
    begin
      for (int b = 7; b >= 0; b--)
      begin
        fb = c[15] ^ d[8*i+b];
        c = {c[14:0], 1'b0};
        if (fb)
        begin
          c = c ^ CRC_POLY;
        end
      end
    end
    return c;
  endfunction : crc16
endpackage : steer_pkg

`default_nettype wire

// ---- steer_link_if.sv ----
// Frame-level link between sensor and controller.
// Assumes both ends on aclk; data byte 0 sits in bits 7:0.
`timescale 1ns/1ns
`default_nettype none

interface steer_link_if;
  // Report frames, sensor to controller
  logic rpt_valid;
  logic rpt_ready;
  logic [10:0] rpt_id;
  logic [63:0] rpt_data;
  // Setup frames, controller to sensor
  logic set_valid;
  logic set_ready;
  logic [10:0] set_id;
  logic [63:0] set_data;
  // Sensor bus driver enable
  logic drv_en;

  modport device (
    output rpt_valid, rpt_id, rpt_data, set_ready, drv_en,
    input rpt_ready, set_valid, set_id, set_data
  );
  modport controller (
    input rpt_valid, rpt_id, rpt_data, set_ready, drv_en,
    output rpt_ready, set_valid, set_id, set_data
  );
endinterface : steer_link_if

`default_nettype wire

// ---- steering_angle_can_reporter.sv ----
// Sensor end: cyclic angle report and two-frame setup sequence.
// Assumes raw_angle and fault are on aclk; por_n resets persistent settings.
// Behaviour
// - Bit rate 125/250/500k, default 250k
// - Report every 5/10/20 ms, default 10
// - Report id 301h, eight data bytes
// - Bytes 0-1: 12-bit angle from zero
// - Clockwise past 4095 wraps to 0
// - Counter-clockwise below 0 wraps to 4095
// - Byte 2 counts up per report
// - Bytes 3-4: signed change since last report
// - Status bit 0: 1 normal, 0 programming
// - Bytes 6-7 carry CRC-16 0x8005
// - Setup frame id 0C0h from controller
// - Setup byte 0 selects bit rate
// - Setup byte 1 selects report period
// - Byte 2 AAh stores current angle zero
// - Opening frame bytes 4,5 = AAh,55h
// - Opening frame acknowledged by status 0
// - Second frame bytes 4,5 = 0Fh,F0h
// - Apply only valid, timely, both CRC good
// - Status returns to 1 after programming
// - Each step within 1 s else fail
// - Internal failure disables bus driver
`timescale 1ns/1ns
`default_nettype none

module steering_angle_can_reporter #(
  parameter int unsigned ms_cycles = steer_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n, // Persistent settings reset
  input wire logic [11:0] raw_angle,
  input wire logic fault,
  steer_link_if.device link,
  output logic [7:0] rate_code,
  output logic [7:0] period_code,
  output logic [11:0] zero_ref,
  output logic prog_active
);

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_ACK = 2'b01,
    P_WAIT2 = 2'b10
  } prog_t;

  prog_t state, next_state;
  logic [31:0] ms_cnt, next_ms_cnt;
  logic [4:0] per_cnt, next_per_cnt;
  logic [9:0] to_cnt, next_to_cnt;
  logic tx_valid, next_tx_valid;
  logic [63:0] tx_data, next_tx_data;
  logic [7:0] count, next_count;
  logic [11:0] prev_angle, next_prev_angle;
  logic drv_on, next_drv_on;
  logic [7:0] new_rate, next_new_rate;
  logic [7:0] new_per, next_new_per;
  logic [7:0] new_zero, next_new_zero;
  logic [7:0] next_rate_code, next_period_code;
  logic [11:0] next_zero_ref;
  logic ms_tick, launch, timeout, rx_id, rx_ok, opening, closing;
  logic [11:0] angle;
  logic [15:0] change;
  logic [47:0] body;
  logic [4:0] per_ms;

  // Code inside the defined range
  function automatic logic in_range(input logic [7:0] c);
    return (c >= steer_pkg::CODE_LO) && (c <= steer_pkg::CODE_HI);
  endfunction : in_range

  ////////////////////////////////////////////////////////////////////////
  // Report content
  always_comb
  begin
    angle = raw_angle - zero_ref;
    change = {4'h0, angle} - {4'h0, prev_angle};
    // Byte 5 status: bit 0 high only when idle, rest zero
    body = {7'h00, state == P_IDLE, change, count, 4'h0, angle};
    case (period_code)
      steer_pkg::CODE_LO: per_ms = 5'(steer_pkg::PER_SHORT_MS);
      steer_pkg::CODE_HI: per_ms = 5'(steer_pkg::PER_LONG_MS);
      default: per_ms = 5'(steer_pkg::PER_MID_MS);
    endcase
  end

  // Setup frame decode
  assign rx_id = link.set_valid && (link.set_id == steer_pkg::SET_ID);
  assign rx_ok = rx_id
    && (steer_pkg::crc16(link.set_data[47:0]) == link.set_data[63:48]);
  assign opening = rx_ok && (link.set_data[39:32] == steer_pkg::OPEN_A)
    && (link.set_data[47:40] == steer_pkg::OPEN_B);
  assign closing = rx_ok && (link.set_data[39:32] == steer_pkg::CLOSE_A)
    && (link.set_data[47:40] == steer_pkg::CLOSE_B);

  // Timing events
  assign ms_tick = (ms_cnt == ms_cycles - 1);
  assign launch = ms_tick && (per_cnt == per_ms - 5'd1) && !tx_valid && drv_on && !fault;
  assign timeout = ms_tick && (to_cnt == 10'(steer_pkg::TIMEOUT_MS - 1));

  ////////////////////////////////////////////////////////////////////////
  // Next state of all control and persistent state
  always_comb
  begin
    next_state = state;
    next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    next_per_cnt = per_cnt;
    next_to_cnt = to_cnt;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_count = count;
    next_prev_angle = prev_angle;
    next_drv_on = drv_on && !fault;
    next_new_rate = new_rate;
    next_new_per = new_per;
    next_new_zero = new_zero;
    next_rate_code = rate_code;
    next_period_code = period_code;
    next_zero_ref = zero_ref;
    // Period counter in ms
    if (ms_tick)
    begin
      next_per_cnt = (per_cnt >= per_ms - 5'd1) ? 5'd0 : per_cnt + 5'd1;
    end
    // Report launch and handover
    if (launch)
    begin
      next_tx_valid = 1'b1;
      next_tx_data = {steer_pkg::crc16(body), body};
      next_count = count + 8'h01;
      next_prev_angle = angle;
    end
    else if (tx_valid && link.rpt_ready)
    begin
      next_tx_valid = 1'b0;
    end
    if (!next_drv_on)
    begin
      next_tx_valid = 1'b0;
    end
    // Timeout counter while programming
    if (state != P_IDLE && ms_tick)
    begin
      next_to_cnt = to_cnt + 10'd1;
    end
    // Programming sequence
    case (state)
      P_IDLE:
      begin
        if (opening)
        begin
          next_new_rate = link.set_data[7:0];
          next_new_per = link.set_data[15:8];
          next_new_zero = link.set_data[23:16];
          next_to_cnt = 10'd0;
          next_state = P_ACK;
        end
      end
      P_ACK:
      begin
        if (launch)
        begin
          next_to_cnt = 10'd0;
          next_state = P_WAIT2;
        end
        else if (timeout)
        begin
          next_state = P_IDLE;
        end
      end
      P_WAIT2:
      begin
        if (rx_id)
        begin
          if (closing && in_range(new_rate) && in_range(new_per))
          begin
            next_rate_code = new_rate;
            next_period_code = new_per;
            if (new_zero == steer_pkg::ZERO_KEY)
            begin
              next_zero_ref = raw_angle;
            end
          end
          next_state = P_IDLE;
        end
        else if (timeout)
        begin
          next_state = P_IDLE;
        end
      end
      default: next_state = P_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= P_IDLE;
      ms_cnt <= 32'h0000_0000;
      per_cnt <= 5'd0;
      to_cnt <= 10'd0;
      tx_valid <= 1'b0;
      tx_data <= 64'h0000_0000_0000_0000;
      count <= steer_pkg::COUNT_RESET;
      prev_angle <= steer_pkg::ZERO_RESET;
      drv_on <= 1'b1;
      new_rate <= steer_pkg::CODE_MID;
      new_per <= steer_pkg::CODE_MID;
      new_zero <= 8'h00;
    end
    else
    begin
      state <= next_state;
      ms_cnt <= next_ms_cnt;
      per_cnt <= next_per_cnt;
      to_cnt <= next_to_cnt;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      count <= next_count;
      prev_angle <= next_prev_angle;
      drv_on <= next_drv_on;
      new_rate <= next_new_rate;
      new_per <= next_new_per;
      new_zero <= next_new_zero;
    end
  end

  // Persistent settings, kept across aresetn
  always_ff @(posedge aclk)
  begin
    if (!por_n)
    begin
      rate_code <= steer_pkg::CODE_MID;
      period_code <= steer_pkg::CODE_MID;
      zero_ref <= steer_pkg::ZERO_RESET;
    end
    else
    begin
      rate_code <= next_rate_code;
      period_code <= next_period_code;
      zero_ref <= next_zero_ref;
    end
  end

  // Link outputs
  assign link.rpt_valid = tx_valid;
  assign link.rpt_id = steer_pkg::RPT_ID;
  assign link.rpt_data = tx_data;
  assign link.set_ready = 1'b1;
  assign link.drv_en = drv_on;
  assign prog_active = (state != P_IDLE);

endmodule : steering_angle_can_reporter

`default_nettype wire

// ---- steering_angle_can_controller.sv ----
// Controller end: AXI4-Lite registers drive the setup sequence.
// Assumes the sensor end on the same aclk across steer_link_if.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module steering_angle_can_controller #(
  parameter int unsigned ms_cycles = steer_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  steer_link_if.controller link
);

  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_SEND1 = 3'b001,
    C_WACK = 3'b010,
    C_SEND2 = 3'b011,
    C_WDONE = 3'b100
  } ctrl_t;

  ctrl_t state, next_state;
  logic [31:0] ms_cnt, next_ms_cnt;
  logic [9:0] to_cnt, next_to_cnt;
  logic set_valid, next_set_valid;
  logic [63:0] set_data, next_set_data;
  logic [7:0] cfg_rate, next_cfg_rate, cfg_per, next_cfg_per;
  logic cfg_zero, next_cfg_zero, done, next_done, fail, next_fail;
  logic [11:0] rep_angle, next_rep_angle;
  logic [7:0] rep_count, next_rep_count;
  logic [15:0] rep_change, next_rep_change;
  logic rep_stat, next_rep_stat;
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr, wa;
  logic [31:0] w_data, next_w_data, wd;
  logic [3:0] w_strb, next_w_strb, ws;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic ms_tick, timeout, rx_ok, have_aw, have_w;

  // Setup frame with given sequence keys
  function automatic logic [63:0] setup_frame(input logic [7:0] rate, input logic [7:0] per,
    input logic zero, input logic [7:0] ka, input logic [7:0] kb);
    logic [47:0] b;
    b = {kb, ka, 8'h00, zero ? steer_pkg::ZERO_KEY : 8'h00, per, rate};
    return {steer_pkg::crc16(b), b};
  endfunction : setup_frame

  ////////////////////////////////////////////////////////////////////////
  // Events
  assign ms_tick = (ms_cnt == ms_cycles - 1);
  assign timeout = ms_tick && (to_cnt == 10'(steer_pkg::TIMEOUT_MS - 1));
  assign rx_ok = link.rpt_valid && (link.rpt_id == steer_pkg::RPT_ID)
    && (steer_pkg::crc16(link.rpt_data[47:0]) == link.rpt_data[63:48]);
  assign have_aw = aw_hold || (awvalid && awready);
  assign have_w = w_hold || (wvalid && wready);
  assign wa = aw_hold ? aw_addr : awaddr;
  assign wd = w_hold ? w_data : wdata;
  assign ws = w_hold ? w_strb : wstrb;

  ////////////////////////////////////////////////////////////////////////
  // Next values of sequence, report capture and bus slave
  always_comb
  begin
    next_state = state;
    next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    next_to_cnt = (ms_tick && state != C_IDLE) ? to_cnt + 10'd1 : to_cnt;
    next_set_valid = set_valid;
    next_set_data = set_data;
    next_cfg_rate = cfg_rate;
    next_cfg_per = cfg_per;
    next_cfg_zero = cfg_zero;
    next_done = done;
    next_fail = fail;
    next_rep_angle = rep_angle;
    next_rep_count = rep_count;
    next_rep_change = rep_change;
    next_rep_stat = rep_stat;
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    // Latest good report
    if (rx_ok)
    begin
      next_rep_angle = link.rpt_data[11:0];
      next_rep_count = link.rpt_data[23:16];
      next_rep_change = link.rpt_data[39:24];
      next_rep_stat = link.rpt_data[40];
    end
    // Setup sequence
    case (state)
      C_IDLE: next_state = C_IDLE;
      C_SEND1, C_SEND2:
      begin
        if (set_valid && link.set_ready)
        begin
          next_set_valid = 1'b0;
          next_to_cnt = 10'd0;
          next_state = (state == C_SEND1) ? C_WACK : C_WDONE;
        end
      end
      C_WACK:
      begin
        if (rx_ok && !link.rpt_data[40])
        begin
          next_set_valid = 1'b1;
          next_set_data = setup_frame(cfg_rate, cfg_per, cfg_zero,
            steer_pkg::CLOSE_A, steer_pkg::CLOSE_B);
          next_state = C_SEND2;
        end
        else if (timeout)
        begin
          next_fail = 1'b1;
          next_state = C_IDLE;
        end
      end
      C_WDONE:
      begin
        if (rx_ok && link.rpt_data[40])
        begin
          next_done = 1'b1;
          next_state = C_IDLE;
        end
        else if (timeout)
        begin
          next_fail = 1'b1;
          next_state = C_IDLE;
        end
      end
      default: next_state = C_IDLE;
    endcase
    // Write channel: address and data in either order
    if (have_aw && have_w)
    begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wa > steer_pkg::REG_CHANGE || wa[1:0] != 2'h0) ?
        steer_pkg::RESP_SLVERR : steer_pkg::RESP_OKAY;
      if (wa == steer_pkg::REG_CFG)
      begin
        next_cfg_rate = ws[0] ? wd[7:0] : cfg_rate;
        next_cfg_per = ws[1] ? wd[15:8] : cfg_per;
        next_cfg_zero = ws[2] ? wd[16] : cfg_zero;
      end
      if (wa == steer_pkg::REG_CMD && ws[0] && wd[0] && state == C_IDLE)
      begin
        next_done = 1'b0;
        next_fail = 1'b0;
        next_set_valid = 1'b1;
        next_set_data = setup_frame(cfg_rate, cfg_per, cfg_zero,
          steer_pkg::OPEN_A, steer_pkg::OPEN_B);
        next_state = C_SEND1;
      end
    end
    else
    begin
      if (awvalid && awready)
      begin
        next_aw_hold = 1'b1;
        next_aw_addr = awaddr;
      end
      if (wvalid && wready)
      begin
        next_w_hold = 1'b1;
        next_w_data = wdata;
        next_w_strb = wstrb;
      end
    end
    // Read channel
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = steer_pkg::RESP_OKAY;
      case (araddr)
        steer_pkg::REG_CMD: next_rdata = {31'h0000_0000, state != C_IDLE};
        steer_pkg::REG_CFG: next_rdata = {15'h0000, cfg_zero, cfg_per, cfg_rate};
        steer_pkg::REG_STATUS:
          next_rdata = {27'h000_0000, link.drv_en, rep_stat, fail, done, state != C_IDLE};
        steer_pkg::REG_REPORT: next_rdata = {8'h00, rep_count, 4'h0, rep_angle};
        steer_pkg::REG_CHANGE: next_rdata = {16'h0000, rep_change};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = steer_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= C_IDLE;
      ms_cnt <= 32'h0000_0000;
      to_cnt <= 10'd0;
      set_valid <= 1'b0;
      set_data <= 64'h0000_0000_0000_0000;
      cfg_rate <= steer_pkg::CODE_MID;
      cfg_per <= steer_pkg::CODE_MID;
      cfg_zero <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      rep_angle <= steer_pkg::ZERO_RESET;
      rep_count <= steer_pkg::COUNT_RESET;
      rep_change <= 16'h0000;
      rep_stat <= 1'b0;
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= steer_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= steer_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      ms_cnt <= next_ms_cnt;
      to_cnt <= next_to_cnt;
      set_valid <= next_set_valid;
      set_data <= next_set_data;
      cfg_rate <= next_cfg_rate;
      cfg_per <= next_cfg_per;
      cfg_zero <= next_cfg_zero;
      done <= next_done;
      fail <= next_fail;
      rep_angle <= next_rep_angle;
      rep_count <= next_rep_count;
      rep_change <= next_rep_change;
      rep_stat <= next_rep_stat;
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Handshake and link outputs
  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign arready = !rvalid;
  assign link.rpt_ready = 1'b1;
  assign link.set_valid = set_valid;
  assign link.set_id = steer_pkg::SET_ID;
  assign link.set_data = set_data;

endmodule : steering_angle_can_controller

`default_nettype wire

// ---- steer_link_assertions.sv ----
// Checker of the link: frame layout, counts, CRC and setup handshake.
// Assumes it sits beside steer_link_if on the single clock aclk.
`timescale 1ns/1ns
`default_nettype none

module steer_link_assertions #(
  parameter int unsigned ms_cycles = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rpt_valid,
  input wire logic rpt_ready,
  input wire logic [10:0] rpt_id,
  input wire logic [63:0] rpt_data,
  input wire logic set_valid,
  input wire logic [10:0] set_id,
  input wire logic [63:0] set_data,
  input wire logic drv_en
);
  localparam int WAIT_MAX = 25 * ms_cycles;
  logic seen, next_seen;
  logic [7:0] cnt, next_cnt;
  logic [11:0] ang, next_ang;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // CRC-16 over bytes 0..5, msb first
  function automatic logic [15:0] crc(input logic [47:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 48; i++)
      c = {c[14:0], 1'b0} ^ (c[15] ^ d[8 * (i / 8) + 7 - i % 8] ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crc

  // Count and angle of the last report taken
  always_comb
  begin
    next_seen = seen | (rpt_valid & rpt_ready);
    next_cnt = (rpt_valid && rpt_ready) ? rpt_data[23:16] : cnt;
    next_ang = (rpt_valid && rpt_ready) ? rpt_data[11:0] : ang;
  end
  always_ff @(posedge aclk)
  begin
    seen <= aresetn & next_seen;
    cnt <= next_cnt;
    ang <= next_ang;
  end

  ////////////////////////////////////////////////////////////
  // Setup handshake steps
  sequence open_s;
    set_valid && set_data[47:32] == 16'h55aa;
  endsequence
  sequence close_s;
    set_valid && set_data[47:32] == 16'hf00f;
  endsequence
  sequence ack_s;
    rpt_valid && !rpt_data[40];
  endsequence
  sequence back_s;
    rpt_valid && rpt_data[40];
  endsequence

  AST_RPT_ID: assert property (rpt_valid |-> rpt_id == 11'h301)
    else $error("report id wrong");
  AST_ANGLE_TOP: assert property (rpt_valid |-> rpt_data[15:12] == 4'h0)
    else $error("angle above 12 bits");
  AST_STATUS_PAD: assert property (rpt_valid |-> rpt_data[47:41] == 7'h00)
    else $error("status pad bits set");
  AST_RPT_CRC: assert property (rpt_valid |-> rpt_data[63:48] == crc(rpt_data[47:0]))
    else $error("report crc wrong");
  AST_SET_CRC: assert property (set_valid |-> set_data[63:48] == crc(set_data[47:0]))
    else $error("setup crc wrong");
  AST_SET_ID: assert property (set_valid |-> set_id == 11'h0c0)
    else $error("setup id wrong");
  AST_COUNT: assert property (seen && rpt_valid && rpt_ready
    |-> rpt_data[23:16] == cnt + 8'h01)
    else $error("rolling count wrong");
  AST_CHANGE: assert property (seen && rpt_valid && rpt_ready
    |-> rpt_data[39:24] == {4'h0, rpt_data[11:0]} - {4'h0, ang})
    else $error("angle change wrong");
  AST_SILENT: assert property (!drv_en |-> !rpt_valid)
    else $error("report while driver off");
  AST_ACK: assert property (open_s |-> ##[1:WAIT_MAX] ack_s)
    else $error("no acknowledge report");
  AST_RESTORE: assert property (close_s |-> ##[1:WAIT_MAX] back_s)
    else $error("status not restored");
endmodule : steer_link_assertions

`default_nettype wire

// ---- steering_angle_can_reporter_bench.sv ----
// Bench: sensor and controller joined by the link, AXI master, report scoreboard.
// Assumes short ms_cycles so report periods take 50 to 200 clocks.
`timescale 1ns/1ns
`default_nettype none

module steering_angle_can_reporter_bench;
  localparam int MSC = 10;
  logic aclk, aresetn = 1'b0, por_n = 1'b0, fault = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, prog_active;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rate_code, period_code;
  logic [7:0] exp_rate = 8'h03, exp_per = 8'h03;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rr;
  logic [11:0] raw_angle = 12'h000, zero_ref, zero = 12'h000, exp_q[$];
  logic [15:0] rnd = 16'ha1bf;
  logic [16:0] cases [4] = '{{8'h02, 8'h02, 1'b0}, {8'h04, 8'h04, 1'b1},
    {8'h05, 8'h03, 1'b0}, {8'h03, 8'h01, 1'b1}};
  int errors = 0, checked = 0, cyc = 0, last_t = 0, per_cyc = 10 * MSC;

  steer_link_if steer_link_if_i ();
  steering_angle_can_reporter #(.ms_cycles(MSC)) steering_angle_can_reporter_i (.aclk,
    .aresetn, .por_n, .raw_angle, .fault, .link(steer_link_if_i), .rate_code,
    .period_code, .zero_ref, .prog_active);
  steering_angle_can_controller #(.ms_cycles(MSC)) steering_angle_can_controller_i (.aclk,
    .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .link(steer_link_if_i));
  steer_link_assertions #(.ms_cycles(MSC)) steer_link_assertions_i (.aclk, .aresetn,
    .rpt_valid(steer_link_if_i.rpt_valid), .rpt_ready(steer_link_if_i.rpt_ready),
    .rpt_id(steer_link_if_i.rpt_id), .rpt_data(steer_link_if_i.rpt_data),
    .set_valid(steer_link_if_i.set_valid), .set_id(steer_link_if_i.set_id),
    .set_data(steer_link_if_i.set_data), .drv_en(steer_link_if_i.drv_en));

  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    check(bresp, steer_pkg::RESP_OKAY);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // New angle after each report, wrap pair first, note the expected value
  task automatic angles(input int n);
    logic [11:0] v;
    for (int k = 0; k < n; k++)
    begin
      rnd = lfsr(rnd);
      v = (k == 1) ? zero : (k < 3) ? zero - 12'h001 : rnd[11:0];
      @(posedge aclk iff steer_link_if_i.rpt_valid);
      raw_angle <= v;
      @(negedge aclk);
      exp_q.push_back(v - zero);
    end
    @(posedge aclk iff steer_link_if_i.rpt_valid);
  endtask : angles

  // Program through registers, wait for the sequence to finish
  task automatic prog(input logic [7:0] r, input logic [7:0] p, input logic z);
    raw_angle <= rnd[11:0];
    axi_write(steer_pkg::REG_CFG, {15'h0000, z, p, r});
    axi_write(steer_pkg::REG_CMD, 32'h0000_0001);
    @(posedge aclk);
    check(prog_active, 1'b1);
    rd = 32'h0000_0000;
    while (rd[2:1] == 2'b00)
      axi_read(steer_pkg::REG_STATUS, rd, rr);
    if (r inside {[8'h02:8'h04]} && p inside {[8'h02:8'h04]})
    begin
      exp_rate = r;
      exp_per = p;
      zero = z ? raw_angle : zero;
    end
    check(rate_code, exp_rate);
    check(period_code, exp_per);
    check(zero_ref, zero);
    check(prog_active, 1'b0);
    per_cyc = (exp_per == 8'h02 ? 5 : exp_per == 8'h04 ? 20 : 10) * MSC;
  endtask : prog

  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  // Report scoreboard
  always @(posedge aclk)
  begin
    if (steer_link_if_i.rpt_valid && steer_link_if_i.rpt_ready)
    begin
      if (exp_q.size() > 0)
      begin
        check(steer_link_if_i.rpt_data[11:0], exp_q.pop_front());
        check(steer_link_if_i.rpt_data[40], 1'b1);
        check(cyc - last_t, per_cyc);
      end
      last_t = cyc;
    end
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    check(rate_code, 8'h03);
    check(period_code, 8'h03);
    angles(6);
    axi_read(8'h40, rd, rr);
    check(rr, steer_pkg::RESP_SLVERR);
    foreach (cases[i])
    begin
      prog(cases[i][16:9], cases[i][8:1], cases[i][0]);
      angles(5);
    end
    fault <= 1'b1;
    repeat (2) @(posedge aclk);
    check(steer_link_if_i.drv_en, 1'b0);
    repeat (300) @(posedge aclk);
    stop_test();
  end

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge aclk);
    errors++;
    stop_test();
  end
endmodule : steering_angle_can_reporter_bench

`default_nettype wire
